// [hw/cfg_link_if.sv]
`timescale 1ns/10ps
interface cfg_link_if;
   logic                         host_clock;
   logic                         dev_clock;
   logic [cfg_pkg::DATA_W-1:0]   data;

   modport dev  (input host_clock, input data, output dev_clock);
   modport host (output host_clock, output data, input dev_clock);
endinterface : cfg_link_if

// [hw/cfg_pkg.sv]
package cfg_pkg;
   localparam int DATA_W         = 8;
   localparam int CLK_PERIOD_PS  = 8000;
   localparam int LINK_PERIOD_PS = 64000;
   // Half period of a link clock made here, rounded down, never below one cycle
   localparam int LINK_HALF_CYC  = (LINK_PERIOD_PS / (2 * CLK_PERIOD_PS)) < 1 ? 1
                                 : LINK_PERIOD_PS / (2 * CLK_PERIOD_PS);
   localparam int LINK_CNT_W     = 4;
   localparam int PP_BEATS_COMP  = 4;
   localparam int PP_BEATS_PLAIN = 1;
   localparam int FIFO_DEPTH     = 32;
   localparam int RUN_FLAG_BIT   = 7;
   localparam int RUN_CNT_W      = 4;

   typedef enum logic [1:0] {
      parallel_passive_load = 2'b00,
      active_serial_load    = 2'b01,
      serial_passive_load   = 2'b10,
      boundary_scan_load    = 2'b11
   } load_mode_t;
endpackage : cfg_pkg

// [hw/config_decompressor.sv]
`timescale 1ns/10ps
// What this block does
// - Expand compressed stream live into configuration cells
// - Compression accepted in parallel, active, passive serial
// - No decompression over boundary-scan; refuse it
// - Host clocks four times the compressed parallel word rate
// - Host holds each compressed parallel word four clocks
// - Compression chosen per device in serial chains
// - Parallel chain devices share one compression setting
// - Expansion outruns the link, never throttling it
module config_decompressor #(
   parameter int DATA_W = cfg_pkg::DATA_W,
   parameter int DEPTH  = cfg_pkg::FIFO_DEPTH
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   cfg_link_if.dev                  link,
   input  wire cfg_pkg::load_mode_t mode,
   input  wire logic                compress_en,
   input  wire logic                load_enable,
   output logic [DATA_W-1:0]        cell_data,
   output logic                     cell_valid,
   input  wire logic                cell_ready,
   output logic                     overrun,
   output logic                     truncated,
   output logic                     decompress_refused
);
   import cfg_pkg::*;

   localparam int BEAT_W = $clog2(DATA_W);

   typedef enum logic [1:0] {
      x_idle    = 2'b00,
      x_run_val = 2'b01,
      x_run_out = 2'b10,
      x_lit     = 2'b11
   } xp_state_t;

   logic [LINK_CNT_W-1:0] div;
   logic [LINK_CNT_W-1:0] next_div;
   logic                  dev_clk;
   logic                  next_dev_clk;
   logic                  clk_s1;
   logic                  clk_s2;
   logic                  clk_s3;
   logic [DATA_W-1:0]     dat_s1;
   logic [DATA_W-1:0]     dat_s2;
   logic                  rise;
   logic                  expand;
   logic [BEAT_W-1:0]     beat;
   logic [BEAT_W-1:0]     next_beat;
   logic [BEAT_W-1:0]     pp_last;
   logic [DATA_W-1:0]     shift;
   logic [DATA_W-1:0]     next_shift;
   logic [DATA_W-1:0]     byte_q;
   logic [DATA_W-1:0]     next_byte_q;
   logic                  byte_stb;
   logic                  next_byte_stb;
   logic                  next_overrun;
   logic                  next_truncated;
   logic                  next_refused;
   logic                  fifo_in_ready;
   logic                  fifo_valid;
   logic                  fifo_pop;
   logic [DATA_W-1:0]     fifo_data;
   xp_state_t             state;
   xp_state_t             next_state;
   logic [RUN_CNT_W-1:0]  count;
   logic [RUN_CNT_W-1:0]  next_count;
   logic [DATA_W-1:0]     run_val;
   logic [DATA_W-1:0]     next_run_val;
   logic [DATA_W-1:0]     next_cell_data;
   logic                  next_cell_valid;
   logic                  out_free;

   assign link.dev_clock = dev_clk;

   // Our own clock goes through the same two stages as the host's so both
   // modes see data and edge with equal delay
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
         dat_s1 <= '0;
         dat_s2 <= '0;
      end else begin
         clk_s1 <= (mode == active_serial_load) ? dev_clk : link.host_clock;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         dat_s1 <= link.data;
         dat_s2 <= dat_s1;
      end
   end

   // Expansion is off over boundary-scan whatever the option says
   assign expand = compress_en && (mode != boundary_scan_load);
   assign rise   = clk_s2 && !clk_s3;
   // Host holds each word for four clocks when compressed
   assign pp_last = expand ? BEAT_W'(PP_BEATS_COMP - 1)
                           : BEAT_W'(PP_BEATS_PLAIN - 1);

   always_comb begin
      next_div      = div;
      next_dev_clk  = dev_clk;
      next_beat     = beat;
      next_shift    = shift;
      next_byte_q   = byte_q;
      next_byte_stb = 1'b0;
      if ((mode == active_serial_load) && load_enable) begin
         if (div == LINK_CNT_W'(LINK_HALF_CYC - 1)) begin
            next_div     = '0;
            next_dev_clk = !dev_clk;
         end else begin
            next_div = div + 1'b1;
         end
      end else begin
         next_div     = '0;
         next_dev_clk = 1'b0;
      end
      if (!load_enable) begin
         next_beat = '0;
      end else if (rise) begin
         case (mode)
            parallel_passive_load: begin
               if (beat == pp_last) begin
                  next_beat     = '0;
                  next_byte_q   = dat_s2;
                  next_byte_stb = 1'b1;
               end else begin
                  next_beat = beat + 1'b1;
               end
            end
            default: begin
               next_shift = {shift[DATA_W-2:0], dat_s2[0]};
               if (beat == BEAT_W'(DATA_W - 1)) begin
                  next_beat     = '0;
                  next_byte_q   = next_shift;
                  next_byte_stb = 1'b1;
               end else begin
                  next_beat = beat + 1'b1;
               end
            end
         endcase
      end
      // A lost byte is flagged; dropping load_enable clears it unless a loss coincides
      next_overrun   = (byte_stb && !fifo_in_ready) || (overrun && load_enable);
      next_truncated = (!load_enable && (state != x_idle))
                       || (truncated && !load_enable);
      next_refused   = compress_en && (mode == boundary_scan_load);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div                <= '0;
         dev_clk            <= 1'b0;
         beat               <= '0;
         shift              <= '0;
         byte_q             <= '0;
         byte_stb           <= 1'b0;
         overrun            <= 1'b0;
         truncated          <= 1'b0;
         decompress_refused <= 1'b0;
      end else begin
         div                <= next_div;
         dev_clk            <= next_dev_clk;
         beat               <= next_beat;
         shift              <= next_shift;
         byte_q             <= next_byte_q;
         byte_stb           <= next_byte_stb;
         overrun            <= next_overrun;
         truncated          <= next_truncated;
         decompress_refused <= next_refused;
      end
   end

   // Only a few words ride here, never the whole image
   stream_fifo #(
      .W     (DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (byte_stb),
      .in_ready  (fifo_in_ready),
      .in_data   (byte_q),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Runs are capped at sixteen words so one token expands in fewer cycles
   // than the link needs to deliver the next one
   always_comb begin
      out_free        = !cell_valid || cell_ready;
      next_state      = state;
      next_count      = count;
      next_run_val    = run_val;
      next_cell_data  = cell_data;
      next_cell_valid = cell_valid && !cell_ready;
      fifo_pop        = 1'b0;
      case (state)
         x_idle: begin
            if (fifo_valid && !expand && out_free) begin
               fifo_pop        = 1'b1;
               next_cell_data  = fifo_data;
               next_cell_valid = 1'b1;
            end else if (fifo_valid && expand) begin
               fifo_pop   = 1'b1;
               next_count = fifo_data[RUN_CNT_W-1:0];
               next_state = fifo_data[RUN_FLAG_BIT] ? x_run_val : x_lit;
            end
         end
         x_run_val: begin
            if (fifo_valid) begin
               fifo_pop     = 1'b1;
               next_run_val = fifo_data;
               next_state   = x_run_out;
            end
         end
         x_run_out: begin
            if (out_free) begin
               next_cell_data  = run_val;
               next_cell_valid = 1'b1;
               next_count      = count - 1'b1;
               if (count == '0) begin
                  next_state = x_idle;
               end
            end
         end
         x_lit: begin
            if (fifo_valid && out_free) begin
               fifo_pop        = 1'b1;
               next_cell_data  = fifo_data;
               next_cell_valid = 1'b1;
               next_count      = count - 1'b1;
               if (count == '0) begin
                  next_state = x_idle;
               end
            end
         end
         default: begin
            next_state = x_idle;
         end
      endcase
      if (!load_enable) begin
         next_state = x_idle;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state      <= x_idle;
         count      <= '0;
         run_val    <= '0;
         cell_data  <= '0;
         cell_valid <= 1'b0;
      end else begin
         state      <= next_state;
         count      <= next_count;
         run_val    <= next_run_val;
         cell_data  <= next_cell_data;
         cell_valid <= next_cell_valid;
      end
   end
endmodule : config_decompressor

// [hw/config_host.sv]
`timescale 1ns/10ps
module config_host #(
   parameter int DATA_W = cfg_pkg::DATA_W
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   cfg_link_if.host                 link,
   input  wire cfg_pkg::load_mode_t mode,
   input  wire logic                compress_en,
   input  wire logic [DATA_W-1:0]   src_data,
   input  wire logic                src_valid,
   output logic                     src_ready,
   output logic                     busy
);
   import cfg_pkg::*;

   localparam int BEAT_W = $clog2(DATA_W);

   logic [LINK_CNT_W-1:0] div;
   logic [LINK_CNT_W-1:0] next_div;
   logic                  hclk;
   logic                  next_hclk;
   logic                  have;
   logic                  next_have;
   logic [BEAT_W-1:0]     beat;
   logic [BEAT_W-1:0]     next_beat;
   logic [BEAT_W-1:0]     last;
   logic [BEAT_W-1:0]     bit_sel;
   logic [DATA_W-1:0]     cur;
   logic [DATA_W-1:0]     next_cur;
   logic [DATA_W-1:0]     pin;
   logic [DATA_W-1:0]     next_pin;
   logic                  as_s1;
   logic                  as_s2;
   logic                  as_s3;
   logic                  own;
   logic                  fall;

   assign link.host_clock = hclk;
   assign link.data       = pin;
   assign busy            = have;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         as_s1 <= 1'b0;
         as_s2 <= 1'b0;
         as_s3 <= 1'b0;
      end else begin
         as_s1 <= link.dev_clock;
         as_s2 <= as_s1;
         as_s3 <= as_s2;
      end
   end

   always_comb begin
      own = (mode != active_serial_load);
      // One setting for every device sharing the parallel clock
      if (mode == parallel_passive_load) begin
         last = compress_en ? BEAT_W'(PP_BEATS_COMP - 1)
                            : BEAT_W'(PP_BEATS_PLAIN - 1);
      end else begin
         last = BEAT_W'(DATA_W - 1);
      end
      fall      = own ? (hclk && (div == LINK_CNT_W'(LINK_HALF_CYC - 1)))
                      : (as_s3 && !as_s2);
      next_div  = div;
      next_hclk = hclk;
      next_have = have;
      next_beat = beat;
      next_cur  = cur;
      src_ready = 1'b0;
      // Clock stands low whenever no word is held
      if (own && have) begin
         if (div == LINK_CNT_W'(LINK_HALF_CYC - 1)) begin
            next_div  = '0;
            next_hclk = !hclk;
         end else begin
            next_div = div + 1'b1;
         end
      end else begin
         next_div  = '0;
         next_hclk = 1'b0;
      end
      if (have && fall) begin
         if (beat == last) begin
            next_beat = '0;
            if (src_valid) begin
               src_ready = 1'b1;
               next_cur  = src_data;
            end else begin
               next_have = 1'b0;
            end
         end else begin
            next_beat = beat + 1'b1;
         end
      end else if (!have && src_valid) begin
         src_ready = 1'b1;
         next_cur  = src_data;
         next_have = 1'b1;
         next_beat = '0;
      end
      bit_sel = BEAT_W'(DATA_W - 1) - next_beat;
      if (mode == parallel_passive_load) begin
         next_pin = next_cur;
      end else begin
         next_pin = {{(DATA_W - 1){1'b0}}, next_cur[bit_sel]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div  <= '0;
         hclk <= 1'b0;
         have <= 1'b0;
         beat <= '0;
         cur  <= '0;
         pin  <= '0;
      end else begin
         div  <= next_div;
         hclk <= next_hclk;
         have <= next_have;
         beat <= next_beat;
         cur  <= next_cur;
         pin  <= next_pin;
      end
   end
endmodule : config_host

// [hw/stream_fifo.sv]
`timescale 1ns/10ps
module stream_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr;
   logic [AW:0]  rd;
   logic [AW:0]  next_wr;
   logic [AW:0]  next_rd;
   logic         push;
   logic         pop;

   always_comb begin
      in_ready  = (wr[AW-1:0] != rd[AW-1:0]) || (wr[AW] == rd[AW]);
      out_valid = (wr != rd);
      out_data  = mem[rd[AW-1:0]];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      next_wr   = push ? wr + 1'b1 : wr;
      next_rd   = pop ? rd + 1'b1 : rd;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr <= '0;
         rd <= '0;
      end else begin
         wr <= next_wr;
         rd <= next_rd;
      end
   end

   // Storage needs no reset; pointers guard every read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr[AW-1:0]] <= in_data;
      end
   end
endmodule : stream_fifo

// [verification/cfg_link_properties.sv]
`timescale 1ns/10ps
module cfg_link_properties (
   input wire logic                       clk,
   input wire logic                       rst_n,
   input wire logic                       host_clock,
   input wire logic                       dev_clock,
   input wire logic [cfg_pkg::DATA_W-1:0] data,
   input wire cfg_pkg::load_mode_t        mode,
   input wire logic                       compress_en
);
   import cfg_pkg::*;
   // Host clock rises since the last data change; modulo four, so a repeated word still fits
   logic [1:0]        rises;
   logic [1:0]        next_rises;
   logic              host_clock_q;
   logic [DATA_W-1:0] data_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always_comb begin
      next_rises = rises;
      if (data != data_q) begin
         next_rises = 2'h0;
      end else if (host_clock && !host_clock_q) begin
         next_rises = rises + 2'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rises        <= 2'h0;
         host_clock_q <= 1'b0;
         data_q       <= '0;
      end else begin
         rises        <= next_rises;
         host_clock_q <= host_clock;
         data_q       <= data;
      end
   end
   sequence s_host_high;
      host_clock [*4] ##1 !host_clock;
   endsequence
   sequence s_dev_high;
      dev_clock [*4] ##1 !dev_clock;
   endsequence
   a_word_beats_four: assert property (
      mode == parallel_passive_load && compress_en && $changed(data) |-> rises == 2'h0)
      else $error("parallel word changed before its fourth clock");
   a_word_beat_single: assert property (
      mode == parallel_passive_load && !compress_en && $changed(data) |-> rises <= 2'h1)
      else $error("plain parallel word held over several clocks");
   a_data_low_change: assert property (
      mode != active_serial_load && $changed(data) |-> !host_clock)
      else $error("link data changed while host clock high");
   a_host_high_phase: assert property ($rose(host_clock) |-> s_host_high)
      else $error("host clock high phase not four cycles");
   a_host_low_phase: assert property ($fell(host_clock) |-> !host_clock [*4])
      else $error("host clock low phase too short");
   a_dev_high_phase: assert property ($rose(dev_clock) |-> s_dev_high)
      else $error("device clock high phase not four cycles");
   a_dev_low_phase: assert property ($fell(dev_clock) |-> !dev_clock [*4])
      else $error("device clock low phase too short");
   a_dev_clock_quiet: assert property (mode != active_serial_load |-> !dev_clock)
      else $error("device clock runs outside active serial");
   a_host_quiet_as: assert property (mode == active_serial_load |-> !host_clock)
      else $error("host clock runs in active serial");
endmodule : cfg_link_properties

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
   import cfg_pkg::*;
   logic              clk;
   logic              rst_n;
   load_mode_t        mode;
   logic              compress_en;
   logic              load_enable;
   logic [DATA_W-1:0] src_data;
   logic              src_valid;
   logic              src_ready;
   logic [DATA_W-1:0] cell_data;
   logic              cell_valid;
   logic              cell_ready;
   logic              overrun;
   logic              truncated;
   logic              decompress_refused;
   logic              stall;
   logic              lossy;
   logic              busy;
   int                fails;
   int                num_checks;
   logic [7:0]        exp_q[$];
   logic [7:0]        tx_q[$];
   cfg_link_if link ();
   config_host config_host_i (.clk(clk), .rst_n(rst_n), .link(link), .mode(mode),
      .compress_en(compress_en), .src_data(src_data), .src_valid(src_valid),
      .src_ready(src_ready), .busy(busy));
   config_decompressor config_decompressor_i (.clk(clk), .rst_n(rst_n), .link(link),
      .mode(mode), .compress_en(compress_en), .load_enable(load_enable),
      .cell_data(cell_data), .cell_valid(cell_valid), .cell_ready(cell_ready),
      .overrun(overrun), .truncated(truncated), .decompress_refused(decompress_refused));
   cfg_link_properties cfg_link_properties_i (.clk(clk), .rst_n(rst_n),
      .host_clock(link.host_clock), .dev_clock(link.dev_clock), .data(link.data),
      .mode(mode), .compress_en(compress_en));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic restart(input load_mode_t m, input logic c);
      rst_n       <= 1'b0;
      load_enable <= 1'b0;
      mode        <= m;
      compress_en <= c;
      src_valid   <= 1'b0;
      lossy       <= 1'b0;
      exp_q.delete();
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      load_enable <= 1'b1;
      @(posedge clk);
   endtask : restart
   // Tokens: runs up to the sixteen-word cap and short literals, spare bits random
   task automatic build(input logic comp);
      logic [7:0] n;
      logic [7:0] v;
      for (int t = 0; t < 4; t++) begin
         n = (t == 0) ? 8'h0f : 8'($urandom % 16);
         v = 8'($urandom);
         if (t % 2 == 0) begin
            tx_q.push_back({1'b1, 3'($urandom), n[3:0]});
            tx_q.push_back(v);
            if (comp) repeat (n + 1) exp_q.push_back(v);
         end else begin
            n = n % 4;
            tx_q.push_back({1'b0, 3'($urandom), n[3:0]});
            repeat (n + 1) begin
               v = 8'($urandom);
               tx_q.push_back(v);
               if (comp) exp_q.push_back(v);
            end
         end
      end
      if (!comp) begin
         // A plain parallel word repeated would look like one word held two clocks
         foreach (tx_q[i]) begin
            if (i > 0 && tx_q[i] == tx_q[i-1]) begin
               tx_q[i] = tx_q[i] ^ 8'h10;
            end
         end
         exp_q = tx_q;
      end
   endtask : build
   task automatic send_all();
      int n;
      foreach (tx_q[i]) begin
         src_data  <= tx_q[i];
         src_valid <= 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (src_ready !== 1'b1 && n < 2000);
      end
      src_valid <= 1'b0;
      tx_q.delete();
   endtask : send_all
   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      check("pending words", 8'h00, 8'(exp_q.size()));
      repeat (16) @(posedge clk);
   endtask : drain
   // Far side stalls at random; the stall flag holds it off to fill the buffer
   always @(posedge clk) begin
      cell_ready <= stall ? 1'b0 : 1'(($urandom % 4) != 0);
   end
   always @(posedge clk) begin
      if (rst_n === 1'b1 && cell_valid === 1'b1 && cell_ready === 1'b1) begin
         if (exp_q.size() != 0) begin
            check("cell_data", exp_q.pop_front(), cell_data);
         end else if (!lossy) begin
            check("spare cell_valid", 8'h00, {7'h00, cell_valid});
         end
      end
   end
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      complete_run();
   end
   initial begin
      load_mode_t modes[6];
      logic       comps[6];
      modes = '{parallel_passive_load, parallel_passive_load, active_serial_load,
                serial_passive_load, serial_passive_load, boundary_scan_load};
      comps = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      rst_n       = 1'b0;
      mode        = parallel_passive_load;
      compress_en = 1'b0;
      load_enable = 1'b0;
      src_data    = 8'h00;
      src_valid   = 1'b0;
      cell_ready  = 1'b0;
      stall       = 1'b0;
      lossy       = 1'b0;
      fails       = 0;
      num_checks  = 0;
      void'($urandom(8903));
      for (int s = 0; s < 6; s++) begin
         restart(modes[s], comps[s]);
         build(comps[s] && modes[s] != boundary_scan_load);
         send_all();
         drain();
         check("overrun", 8'h00, {7'h00, overrun});
         check("refused", {7'h00, modes[s] == boundary_scan_load && comps[s]},
               {7'h00, decompress_refused});
         check("truncated", 8'h00, {7'h00, truncated});
         check("busy", 8'h00, {7'h00, busy});
      end
      // Far side held off: the buffer fills, later bytes are lost, the first ones survive
      restart(parallel_passive_load, 1'b0);
      stall <= 1'b1;
      lossy <= 1'b1;
      for (int i = 0; i < 40; i++) tx_q.push_back(8'(i));
      // The cell register holds one word beyond the buffer's depth
      for (int i = 0; i <= FIFO_DEPTH; i++) exp_q.push_back(8'(i));
      send_all();
      repeat (32) @(posedge clk);
      check("overrun", 8'h01, {7'h00, overrun});
      stall <= 1'b0;
      drain();
      // Load dropped in mid-token
      restart(parallel_passive_load, 1'b1);
      tx_q = '{8'h03, 8'h5a};
      exp_q.push_back(8'h5a);
      send_all();
      drain();
      load_enable <= 1'b0;
      repeat (4) @(posedge clk);
      check("truncated", 8'h01, {7'h00, truncated});
      complete_run();
   end
endmodule : tb
